// >>> hw/sdvc_top.v
`timescale 1ns/10ps
`default_nettype none

`include "sdvc_defs.vh"

// Functional notes
// R1 - Result leaves on one pin as a single-bit interpolated stream.
// R2 - Code width is programmable from 9 to 16 bits.
// R3 - Output takes only the levels 0 and 1, by sigma-delta interpolation.
// R4 - Density of ones makes the average proportional to the input code.
// R5 - Interpolation rate follows the selected resolution and divider.
// R6 - In transport stream mode the output steers the system clock oscillator.
// R7 - Control at 0x000, input code at 0x004, divider at 0x008; rest reserved.
// R8 - Each divided tick adds code into accumulator; overflow drives output high.
module sdvc_top (
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  // Register port
  input  wire        reg_sel,
  input  wire        reg_we,
  input  wire [11:0] reg_addr,
  input  wire [31:0] reg_wdata,
  output reg  [31:0] reg_rdata,
  output reg         reg_ack,
  // Video port mode
  input  wire        transport_stream_mode,
  // Converter output
  output reg         dac_bit_out,
  output reg         stc_vcxo_ctrl
);

  // Software-visible state. Only the bits that the converter uses are kept.
  reg  [3:0]  interp_control_reg_q;
  reg  [3:0]  interp_control_reg_d;
  reg  [15:0] interp_input_code_reg_q;
  reg  [15:0] interp_input_code_reg_d;
  reg  [15:0] interp_clock_divider_reg_q;
  reg  [15:0] interp_clock_divider_reg_d;

  // Interpolation tick divider.
  reg  [15:0] div_cnt_q;
  reg  [15:0] div_cnt_d;
  reg         tick_q;
  reg         tick_d;

  // Register read port.
  reg  [31:0] rdata_d;
  reg  [31:0] reg_rdata_d;
  reg         reg_ack_d;

  // Output stage.
  reg         dac_bit_out_d;
  reg         stc_vcxo_ctrl_d;

  // Address decode; every other offset in the window is reserved.
  wire        hit_ctrl = (reg_addr == `SDVC_OFS_CTRL);
  wire        hit_code = (reg_addr == `SDVC_OFS_CODE);
  wire        hit_div  = (reg_addr == `SDVC_OFS_DIV);
  wire        wr_en    = reg_sel & reg_we;
  wire        rd_en    = reg_sel & ~reg_we;

  // Control fields; the code width is nine plus the precision field.
  wire        enable   = interp_control_reg_q[`SDVC_CTRL_EN_BIT];
  wire [2:0]  prec_sel = interp_control_reg_q[`SDVC_CTRL_PREC_MSB:`SDVC_CTRL_PREC_LSB];

  // Converter timing. The divider wraps once the count reaches the programmed value.
  wire        div_wrap = (div_cnt_q >= interp_clock_divider_reg_q);
  // Accumulator carry; it changes only on ticks, or when disable clears it.
  wire        carry;

  // Control register. Bits 8 and 9 of the control word are status only and
  // are never stored.
  always @* begin
    interp_control_reg_d = interp_control_reg_q;
    if (wr_en && hit_ctrl) begin
      interp_control_reg_d = reg_wdata[`SDVC_CTRL_PREC_MSB:0]; // R2 R7
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      interp_control_reg_q <= `SDVC_CTRL_RST;
    end else begin
      interp_control_reg_q <= interp_control_reg_d;
    end
  end

  // Input code register. The code is stored whole and masked by the
  // converter, so a later precision change needs no rewrite of the code.
  always @* begin
    interp_input_code_reg_d = interp_input_code_reg_q;
    if (wr_en && hit_code) begin
      interp_input_code_reg_d = reg_wdata[15:0]; // R7
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      interp_input_code_reg_q <= `SDVC_CODE_RST;
    end else begin
      interp_input_code_reg_q <= interp_input_code_reg_d;
    end
  end

  // Divider register. A write to a reserved offset matches no register and
  // is dropped.
  always @* begin
    interp_clock_divider_reg_d = interp_clock_divider_reg_q;
    if (wr_en && hit_div) begin
      interp_clock_divider_reg_d = reg_wdata[15:0]; // R7
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      interp_clock_divider_reg_q <= `SDVC_DIV_RST;
    end else begin
      interp_clock_divider_reg_q <= interp_clock_divider_reg_d;
    end
  end

  // Read mux; reserved offsets and bits read as zero.
  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `SDVC_OFS_CTRL: begin
        rdata_d[`SDVC_CTRL_PREC_MSB:0] = interp_control_reg_q;
        rdata_d[`SDVC_CTRL_TSI_BIT]    = transport_stream_mode;
        rdata_d[`SDVC_CTRL_OUT_BIT]    = dac_bit_out;
      end
      `SDVC_OFS_CODE: begin
        rdata_d[15:0] = interp_input_code_reg_q;
      end
      `SDVC_OFS_DIV: begin
        rdata_d[15:0] = interp_clock_divider_reg_q;
      end
      default: begin
        rdata_d = 32'h00000000; // R7
      end
    endcase
  end

  // Every access is acknowledged one cycle later, reserved offsets included,
  // so software never waits on a hole in the map.
  always @* begin
    reg_ack_d   = reg_sel;
    reg_rdata_d = 32'h00000000;
    if (rd_en) begin
      reg_rdata_d = rdata_d;
    end
  end

  // Read data is registered so that it stands in the cycle of the acknowledge.
  // A write returns zero data.
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h00000000;
      reg_ack   <= 1'b0;
    end else begin
      reg_ack   <= reg_ack_d;
      reg_rdata <= reg_rdata_d;
    end
  end

  // Divider: one interpolation tick every divider+1 core clocks. A full
  // sigma-delta period spans 2^width ticks, so resolution trades against
  // the rate at which the output pattern repeats. A divider of zero ticks
  // on every clock.
  always @* begin
    div_cnt_d = div_cnt_q + 16'h0001;
    tick_d    = 1'b0;
    if (!enable) begin
      div_cnt_d = 16'h0000;
    end else if (div_wrap) begin
      div_cnt_d = 16'h0000;
      tick_d    = 1'b1; // R5
    end
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_q <= 16'h0000;
      tick_q    <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      tick_q    <= tick_d;
    end
  end

  // The accumulator runs only on ticks; its carry is the next output bit.
  // Disable clears it at once, so a re-enabled converter starts from zero.
  sdvc_accum u_accum (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .tick     (tick_q),
    .enable   (enable),
    .prec_sel (prec_sel),
    .code     (interp_input_code_reg_q),
    .carry_q  (carry)
  );

  // The carry holds between ticks, so the pin toggles no faster than the tick.
  // The steering pin follows the bit only in transport stream mode and rests
  // low otherwise; both pins change on the same edge.
  always @* begin
    dac_bit_out_d   = carry;                         // R1 R3 R4
    stc_vcxo_ctrl_d = carry & transport_stream_mode; // R6
  end

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dac_bit_out   <= 1'b0;
      stc_vcxo_ctrl <= 1'b0;
    end else begin
      dac_bit_out   <= dac_bit_out_d;
      stc_vcxo_ctrl <= stc_vcxo_ctrl_d;
    end
  end

endmodule // sdvc_top

`default_nettype wire

// >>> hw/sdvc_defs.vh
`ifndef SDVC_DEFS_VH
`define SDVC_DEFS_VH

// Register offsets within the block's window.
`define SDVC_OFS_CTRL        12'h000
`define SDVC_OFS_CODE        12'h004
`define SDVC_OFS_DIV         12'h008

// Control register fields.
`define SDVC_CTRL_EN_BIT     0
`define SDVC_CTRL_PREC_LSB   1
`define SDVC_CTRL_PREC_MSB   3
`define SDVC_CTRL_TSI_BIT    8
`define SDVC_CTRL_OUT_BIT    9

// Reset values.
`define SDVC_CTRL_RST        4'h0
`define SDVC_CODE_RST        16'h0000
`define SDVC_DIV_RST         16'h0000

// Precision limits: code width is the minimum plus the select field.
`define SDVC_MIN_BITS        5'h09
`define SDVC_MAX_BITS        16

`endif

// >>> hw/sdvc_accum.v
`timescale 1ns/10ps
`default_nettype none

`include "sdvc_defs.vh"

module sdvc_accum (
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  // Control
  input  wire        tick,
  input  wire        enable,
  input  wire [2:0]  prec_sel,
  input  wire [15:0] code,
  // Result
  output reg         carry_q
);

  reg  [15:0] acc_q;
  wire [4:0]  width;
  wire [15:0] mask;
  wire [16:0] sum;
  wire [15:0] sum_masked;
  wire        carry_d;

  // Code width in bits: the minimum plus the precision select, 9 to 16.
  assign width = {2'b00, prec_sel} + `SDVC_MIN_BITS;

  // Bit i is kept when it lies below the selected code width.
  genvar i;
  generate
    for (i = 0; i < `SDVC_MAX_BITS; i = i + 1) begin : g_mask
      assign mask[i] = (i < width) ? 1'b1 : 1'b0; // R2
    end
  endgenerate

  assign sum        = {1'b0, acc_q & mask} + {1'b0, code & mask};
  assign sum_masked = sum[15:0] & mask;
  // Carry out of the top bit of the selected width is the overflow.
  assign carry_d    = (sum[16:0] > {1'b0, mask}) ? 1'b1 : 1'b0; // R8

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_q   <= 16'h0000;
      carry_q <= 1'b0;
    end else if (!enable) begin
      acc_q   <= 16'h0000;
      carry_q <= 1'b0;
    end else if (tick) begin
      acc_q   <= sum_masked; // R8
      carry_q <= carry_d;    // R3
    end
  end

endmodule // sdvc_accum

`default_nettype wire

// >>> tb/sdvc_props.sv
`timescale 1ns/10ps
`default_nettype none
module sdvc_props (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic        reg_sel,
  input wire logic        reg_we,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_ack,
  input wire logic        transport_stream_mode,
  input wire logic        dac_bit_out,
  input wire logic        stc_vcxo_ctrl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_rdctl; reg_sel && !reg_we && reg_addr == 12'h000; endsequence
  property p_ack; reg_sel |=> reg_ack; endproperty
  property p_nak; reg_ack |-> $past(reg_sel); endproperty
  property p_rd0; !reg_ack |-> reg_rdata == 32'h0; endproperty
  property p_unm; reg_sel && !reg_we && reg_addr > 12'h008 |=> reg_rdata == 32'h0; endproperty
  property p_rbit; s_rdctl |=> reg_rdata[9] == $past(dac_bit_out); endproperty
  property p_rtsi; s_rdctl |=> reg_rdata[8] == $past(transport_stream_mode); endproperty
  property p_dis; reg_sel && reg_we && reg_addr == 12'h000 && !reg_wdata[0] |-> ##2 !dac_bit_out; endproperty
  property p_stc; stc_vcxo_ctrl == (dac_bit_out && $past(transport_stream_mode)); endproperty
  a_ack: assert property (p_ack) else $error("no ack after access");
  a_nak: assert property (p_nak) else $error("ack without access");
  a_rd0: assert property (p_rd0) else $error("read data outside ack");
  a_unm: assert property (p_unm) else $error("reserved read not zero");
  a_rbit: assert property (p_rbit) else $error("output bit readback wrong");
  a_rtsi: assert property (p_rtsi) else $error("mode readback wrong");
  a_dis: assert property (p_dis) else $error("output high when disabled");
  a_stc: assert property (p_stc) else $error("oscillator steering wrong");
endmodule // sdvc_props
`default_nettype wire

// >>> tb/sdvc_vcxo.sv
`timescale 1ns/10ps
`default_nettype none
// The filter is an ideal integrator of high levels; jitter is not modelled.
module sdvc_vcxo (
  input wire logic        core_clk,
  input wire logic        clr,
  input wire logic        ctrl,
  output logic     [15:0] ones
);
  always @(posedge core_clk) ones <= clr ? 16'h0 : ones + {15'h0, ctrl};
endmodule // sdvc_vcxo
`default_nettype wire

// >>> tb/test_sigma_delta_vcxo_dac.sv
`timescale 1ns/10ps
`default_nettype none
module test_sigma_delta_vcxo_dac;
  logic core_clk = 0, reset_n = 0, reg_sel = 0, reg_we = 0, tsm = 0, dac, stc, ack, clr = 0;
  logic [11:0] reg_addr = 12'h0;
  logic [31:0] reg_wdata = 32'h0, rdata;
  logic [15:0] ones;
  integer n_errors = 0, n_tests = 0;
  always #2.5 core_clk = ~core_clk;
  sdvc_top dut_u (.core_clk(core_clk), .reset_n(reset_n), .reg_sel(reg_sel), .reg_we(reg_we),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_ack(ack),
    .transport_stream_mode(tsm), .dac_bit_out(dac), .stc_vcxo_ctrl(stc));
  sdvc_vcxo vcxo_u (.core_clk(core_clk), .clr(clr), .ctrl(stc), .ones(ones));
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task rw(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    reg_sel = 1; reg_we = w; reg_addr = a; reg_wdata = d;
    @(negedge core_clk) reg_sel = 0;
    chk("ack", 1, {31'h0, ack});
    q = rdata;
    @(negedge core_clk);
  endtask
  task t_regs;
    logic [31:0] q;
    for (int i = 0; i < 12; i += 4) begin rw(0, i, 0, q); chk("reset", 0, q); end
    rw(1, 12'h00C, 32'hFFFF, q); rw(0, 12'h00C, 0, q); chk("reserved", 0, q);
    rw(1, 12'h004, 32'h5A5A, q); rw(0, 12'h004, 0, q); chk("code", 32'h5A5A, q);
  endtask
  // A full period of 2^width ticks holds exactly the masked code in ones, whatever the phase;
  // each bit stands for divider+1 clocks.
  task t_run(input logic [2:0] sel, input logic [15:0] dv, input logic m, input logic [15:0] e);
    logic [31:0] q;
    logic [31:0] n;
    tsm = m; rw(1, 12'h008, {16'h0, dv}, q); rw(1, 12'h004, 32'h1234, q);
    rw(1, 12'h000, {28'h0, sel, 1'b1}, q);
    repeat (40) @(negedge core_clk);
    clr = 1; @(negedge core_clk) clr = 0; n = 0;
    for (int i = 0; i < (1 << (9 + sel)) * (dv + 1); i++) begin @(negedge core_clk); n += dac; end
    chk("ones", {16'h0, e} * (dv + 1), n);
    chk("stc", m ? {16'h0, e} * (dv + 1) : 0, {16'h0, ones});
    rw(0, 12'h000, 0, q); chk("mode", {31'h0, m}, {31'h0, q[8]});
    rw(1, 12'h000, 0, q);
    @(negedge core_clk);
    chk("off", 0, {31'h0, dac});
  endtask
  task tally_and_finish;
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    reset_n = 1;
    t_regs;
    t_run(3'h0, 16'h2, 1'b1, 16'h0034);
    t_run(3'h7, 16'h0, 1'b0, 16'h1234);
    tally_and_finish;
  end
  initial begin
    #450000;
    n_errors++;
    tally_and_finish;
  end
endmodule // test_sigma_delta_vcxo_dac
bind sdvc_top sdvc_props props_u (.*);
`default_nettype wire
